// File: design/rtca_alarm_if.sv
/*
  carrier between the register block, the comparator and the interrupt unit.
  assumes all three sit on the same clock.
*/
`timescale 1ns/1ps
interface rtca_alarm_if;
  logic evt;
  logic alarm_irq_enable;
  logic clr;
  logic af;
  logic drive;

  modport match_mp (output evt);
  modport irq_mp (input evt, input alarm_irq_enable, input clr, output af, output drive);
  modport ctl_mp (input evt, input af, input drive, output alarm_irq_enable, output clr);
endinterface : rtca_alarm_if

// File: design/rtca_alarm_top.sv
/*
  alarm interrupt unit of a real-time clock: alarm registers, week/date select,
  global reset bit, sticky alarm flag and the open-drain interrupt line.
  assumes a simple synchronous register port from the host interface logic and
  running time counts with a one-cycle minute update pulse from the time keeper.
*/
`timescale 1ns/1ps
`include "rtca_defines.svh"
module rtca_alarm_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // running time
  input wire logic min_tick,
  input wire logic [7:0] min_cnt,
  input wire logic [7:0] hour_cnt,
  input wire logic [7:0] wday_cnt,
  input wire logic [7:0] date_cnt,
  // open-drain interrupt line
  input wire logic int_n_i,
  output logic int_n_o,
  output logic int_n_oe_n
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  rtca_pkg::rtca_regs_t st_q, st_d;
  rtca_alarm_if al ();
  logic wr_min, wr_hour, wr_date, wr_ext, wr_flag, wr_ctl;
  logic [7:0] rd_mux;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  always_comb begin
    wr_min = reg_wr && (reg_addr == `RTCA_OFF_MIN_ALM);
    wr_hour = reg_wr && (reg_addr == `RTCA_OFF_HOUR_ALM);
    wr_date = reg_wr && (reg_addr == `RTCA_OFF_DATE_ALM);
    wr_ext = reg_wr && (reg_addr == `RTCA_OFF_EXT_CFG);
    wr_flag = reg_wr && (reg_addr == `RTCA_OFF_FLAGS);
    wr_ctl = reg_wr && (reg_addr == `RTCA_OFF_IRQ_CTL);
  end

  // writing one is ignored, zero clears
  assign al.clr = wr_flag && !reg_wdata[`RTCA_AF_BIT];
  assign al.alarm_irq_enable = st_q.irq_ctl[`RTCA_AIE_BIT];

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    case (reg_addr)
      `RTCA_OFF_MIN_CNT: begin
        rd_mux = min_cnt & `RTCA_MIN_MASK;
      end
      `RTCA_OFF_HOUR_CNT: begin
        rd_mux = hour_cnt & `RTCA_HOUR_MASK;
      end
      `RTCA_OFF_WDAY_CNT: begin
        rd_mux = wday_cnt & `RTCA_WDAY_MASK;
      end
      `RTCA_OFF_DATE_CNT: begin
        rd_mux = date_cnt & `RTCA_HOUR_MASK;
      end
      `RTCA_OFF_MIN_ALM: begin
        rd_mux = st_q.min_alm;
      end
      `RTCA_OFF_HOUR_ALM: begin
        rd_mux = st_q.hour_alm;
      end
      `RTCA_OFF_DATE_ALM: begin
        rd_mux = st_q.date_alm;
      end
      `RTCA_OFF_EXT_CFG: begin
        rd_mux = st_q.ext_cfg;
      end
      `RTCA_OFF_FLAGS: begin
        rd_mux = 8'h00;
        rd_mux[`RTCA_AF_BIT] = al.af;
      end
      `RTCA_OFF_IRQ_CTL: begin
        rd_mux = st_q.irq_ctl;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    // alarm registers double as plain storage when alarms are unused
    if (wr_min) begin
      st_d.min_alm = reg_wdata;
    end
    if (wr_hour) begin
      st_d.hour_alm = reg_wdata;
    end
    if (wr_date) begin
      st_d.date_alm = reg_wdata;
    end
    if (wr_ext) begin
      st_d.ext_cfg = reg_wdata;
    end
    if (wr_ctl) begin
      // bit 1 is fixed zero
      st_d.irq_ctl = reg_wdata & `RTCA_CTL_WMASK;
    end
    if (reg_rd) begin
      st_d.rdata = rd_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q.min_alm <= `RTCA_ALM_RST;
      st_q.hour_alm <= `RTCA_ALM_RST;
      st_q.date_alm <= `RTCA_ALM_RST;
      st_q.ext_cfg <= `RTCA_EXT_RST;
      st_q.irq_ctl <= `RTCA_CTL_RST;
      st_q.rdata <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;

  // ----------------------------------------
  // comparator and interrupt unit
  // ----------------------------------------
  rtca_match u_match (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .min_tick(min_tick),
    .min_cnt(min_cnt),
    .hour_cnt(hour_cnt),
    .wday_cnt(wday_cnt),
    .date_cnt(date_cnt),
    .min_alm(st_q.min_alm),
    .hour_alm(st_q.hour_alm),
    .date_alm(st_q.date_alm),
    .wdsel(st_q.ext_cfg[`RTCA_WDSEL_BIT]),
    .grst(st_q.irq_ctl[`RTCA_GRST_BIT]),
    .al(al.match_mp)
  );

  rtca_irq u_irq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .al(al.irq_mp)
  );

  // ----------------------------------------
  // open-drain line
  // ----------------------------------------
  // only ever pulls low; the wired level comes back on int_n_i, where other
  // sources may also hold it low, so it is not used to judge the alarm
  assign int_n_o = 1'b0;
  assign int_n_oe_n = !al.drive;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence flag_write_one_seq;
    wr_flag && reg_wdata[`RTCA_AF_BIT] && al.af;
  endsequence

  sequence aie_drop_seq;
    wr_ctl && !reg_wdata[`RTCA_AIE_BIT] && !int_n_oe_n;
  endsequence

  write_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flag_write_one_seq |=> al.af) else $error("writing one changed the alarm flag");
  aie_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    aie_drop_seq |=> ##1 int_n_oe_n) else $error("line not released after enable cleared");
  match_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    al.evt && al.alarm_irq_enable |=> !int_n_oe_n && al.af) else $error("enabled alarm did not pull line low");
  fixed_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st_q.irq_ctl[1] && st_q.rdata[7:4] == 4'h0 || !$past(reg_addr == `RTCA_OFF_FLAGS && reg_rd))
    else $error("fixed zero bit read as one");
  ram_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_hour ##1 !wr_hour |-> st_q.hour_alm == $past(reg_wdata))
    else $error("hour alarm storage lost written value");
  no_evt_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !min_tick |=> !al.evt) else $error("alarm event without time update");
  date_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    min_tick && st_q.ext_cfg[6] && !st_q.irq_ctl[0] && st_q.min_alm[7] && st_q.hour_alm[7]
    && !st_q.date_alm[7] && st_q.date_alm[5:0] != date_cnt[5:0] |=> !al.evt)
    else $error("date mode fired on wrong date");
  week_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    min_tick && !st_q.ext_cfg[6] && !st_q.irq_ctl[0] && st_q.min_alm[7] && st_q.hour_alm[7]
    && !st_q.date_alm[7] && |(st_q.date_alm[6:0] & wday_cnt[6:0]) |=> al.evt)
    else $error("weekday mask hit did not fire");
  excl_day_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    min_tick && !st_q.irq_ctl[0] && st_q.date_alm[7]
    && st_q.min_alm == (min_cnt & 8'h7F) && st_q.hour_alm == (hour_cnt & 8'h3F) |=> al.evt)
    else $error("excluded day register blocked the alarm");
  line_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    al.evt && !al.alarm_irq_enable && int_n_oe_n |=> int_n_oe_n && al.af)
    else $error("disabled alarm pulled the line");

  // ----------------------------------------
  // compare, read-back and line checks
  // ----------------------------------------
  // minute and hour both excluded, so the day register alone decides
  sequence day_only_seq;
    min_tick && !st_q.irq_ctl[`RTCA_GRST_BIT]
    && st_q.min_alm[`RTCA_EXCL_BIT] && st_q.hour_alm[`RTCA_EXCL_BIT]
    && !st_q.date_alm[`RTCA_EXCL_BIT];
  endsequence

  sequence min_miss_seq;
    min_tick && !st_q.min_alm[`RTCA_EXCL_BIT] && st_q.min_alm[6:0] != min_cnt[6:0];
  endsequence

  sequence hour_miss_seq;
    min_tick && !st_q.hour_alm[`RTCA_EXCL_BIT] && st_q.hour_alm[5:0] != hour_cnt[5:0];
  endsequence

  sequence flag_zero_seq;
    al.clr && !al.evt;
  endsequence

  date_hit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    day_only_seq ##0 (st_q.ext_cfg[`RTCA_WDSEL_BIT] && st_q.date_alm[5:0] == date_cnt[5:0]) |=> al.evt)
    else $error("date mode missed a matching date");
  week_miss_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    day_only_seq ##0 (!st_q.ext_cfg[`RTCA_WDSEL_BIT] && (st_q.date_alm[6:0] & wday_cnt[6:0]) == 7'h00)
    |=> !al.evt) else $error("weekday mask fired on an unmarked day");
  min_miss_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    min_miss_seq |=> !al.evt) else $error("alarm fired on a wrong minute");
  hour_miss_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hour_miss_seq |=> !al.evt) else $error("alarm fired on a wrong hour");
  grst_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    min_tick && st_q.irq_ctl[`RTCA_GRST_BIT] |=> !al.evt ##1 !$rose(al.af))
    else $error("alarm flag set under global reset");
  flag_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flag_zero_seq |=> !al.af && int_n_oe_n) else $error("writing zero left the flag or the line set");
  flag_one_line_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_flag && reg_wdata[`RTCA_AF_BIT] && al.alarm_irq_enable && !int_n_oe_n |=> !int_n_oe_n)
    else $error("writing one released the line");
  line_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(int_n_oe_n) |-> $past(al.evt) && $past(al.alarm_irq_enable))
    else $error("line pulled without an enabled event");
  // the wired level may be low for others too, so only the pulling case is judged
  wired_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !int_n_oe_n |-> !int_n_i) else $error("wired line high while the alarm pulls it");
  flag_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == `RTCA_OFF_FLAGS |=> reg_rdata == {4'h0, $past(al.af), 3'h0})
    else $error("flag read did not show the flag");
  ctl_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == `RTCA_OFF_IRQ_CTL |=> !reg_rdata[1])
    else $error("fixed zero control bit read as one");
  count_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr >= `RTCA_OFF_MIN_CNT && reg_addr <= `RTCA_OFF_DATE_CNT |=> !reg_rdata[7])
    else $error("fixed zero count bit read as one");
  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && (reg_addr inside {4'h0, 4'h5, 4'h6, 4'h7, 4'hB, 4'hC}) |=> reg_rdata == 8'h00)
    else $error("unmapped index read non-zero");
  date_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_date ##1 !wr_date |-> st_q.date_alm == $past(reg_wdata))
    else $error("day alarm storage lost written value");
  // read data stands between reads, so a slow host may pick it up late
  rdata_stands_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata)) else $error("read data changed without a read");
endmodule : rtca_alarm_top

// File: design/rtca_defines.svh
/*
  register offsets, field positions, masks and reset values of the alarm unit.
  assumes a 4-bit register index; the upper mirror bank is decoded outside.
*/
`ifndef RTCA_DEFINES_SVH
`define RTCA_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RTCA_OFF_MIN_CNT 4'h1
`define RTCA_OFF_HOUR_CNT 4'h2
`define RTCA_OFF_WDAY_CNT 4'h3
`define RTCA_OFF_DATE_CNT 4'h4
`define RTCA_OFF_MIN_ALM 4'h8
`define RTCA_OFF_HOUR_ALM 4'h9
`define RTCA_OFF_DATE_ALM 4'hA
`define RTCA_OFF_EXT_CFG 4'hD
`define RTCA_OFF_FLAGS 4'hE
`define RTCA_OFF_IRQ_CTL 4'hF
// ----------------------------------------
// fields and masks
// ----------------------------------------
`define RTCA_EXCL_BIT 7
`define RTCA_WDSEL_BIT 6
`define RTCA_AF_BIT 3
`define RTCA_AIE_BIT 3
`define RTCA_GRST_BIT 0
`define RTCA_MIN_MASK 8'h7F
`define RTCA_HOUR_MASK 8'h3F
`define RTCA_WDAY_MASK 8'h7F
`define RTCA_CTL_WMASK 8'hFD
// ----------------------------------------
// reset values
// ----------------------------------------
`define RTCA_ALM_RST 8'h00
`define RTCA_EXT_RST 8'h00
`define RTCA_CTL_RST 8'h00
`endif

// File: design/rtca_irq.sv
/*
  sticky alarm flag and the alarm's share of the open-drain interrupt line.
  assumes clr is one cycle per write of zero to the flag.
*/
`timescale 1ns/1ps
module rtca_irq (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // carrier
  rtca_alarm_if.irq_mp al
);
  rtca_pkg::rtca_irq_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    // set beats a clear in the same cycle
    st_d.af = al.evt || (st_q.af && !al.clr);
    // drive only while enabled, dropped as soon as the enable clears; no timeout
    st_d.drive = al.alarm_irq_enable && (al.evt || (st_q.drive && !al.clr));
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign al.af = st_q.af;
  assign al.drive = st_q.drive;

  sequence clr_seq;
    al.clr && !al.evt;
  endsequence

  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q.af && !al.clr |=> st_q.af) else $error("alarm flag dropped without clear");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clr_seq |=> !st_q.af && !st_q.drive) else $error("clear did not release flag and line");
  evt_sets_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    al.evt |=> st_q.af) else $error("event did not set flag");
  aie_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !al.alarm_irq_enable |=> !st_q.drive) else $error("line driven with enable off");
  drive_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q.drive && al.alarm_irq_enable && !al.clr |=> st_q.drive) else $error("line released on its own");
endmodule : rtca_irq

// File: design/rtca_match.sv
/*
  alarm comparator: one event pulse per matching minute update while grst is clear.
  assumes min_tick is one cycle long and the count inputs already hold the new time.
*/
`timescale 1ns/1ps
`include "rtca_defines.svh"
module rtca_match (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // running time
  input wire logic min_tick,
  input wire logic [7:0] min_cnt,
  input wire logic [7:0] hour_cnt,
  input wire logic [7:0] wday_cnt,
  input wire logic [7:0] date_cnt,
  // settings
  input wire logic [7:0] min_alm,
  input wire logic [7:0] hour_alm,
  input wire logic [7:0] date_alm,
  input wire logic wdsel,
  input wire logic grst,
  // event out
  rtca_alarm_if.match_mp al
);
  rtca_pkg::rtca_match_st_t st_q, st_d;
  logic min_ok, hour_ok, day_ok;

  always_comb begin
    min_ok = min_alm[`RTCA_EXCL_BIT] || (min_alm[6:0] == min_cnt[6:0]);
    hour_ok = hour_alm[`RTCA_EXCL_BIT] || (hour_alm[5:0] == hour_cnt[5:0]);
    // one register, two meanings
    if (wdsel) begin
      day_ok = date_alm[5:0] == date_cnt[5:0];
    end else begin
      day_ok = |(date_alm[6:0] & wday_cnt[6:0]);
    end
    day_ok = day_ok || date_alm[`RTCA_EXCL_BIT];
    st_d = st_q;
    // only on an update, so a time set equal to now stays quiet
    st_d.evt = min_tick && !grst && min_ok && hour_ok && day_ok;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign al.evt = st_q.evt;

  evt_needs_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q.evt |-> $past(min_tick)) else $error("alarm event without minute update");
  evt_held_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    grst && min_tick |=> !st_q.evt) else $error("alarm event under global reset");
  all_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    min_tick && !grst && min_alm[7] && hour_alm[7] && date_alm[7] |=> st_q.evt)
    else $error("fully excluded alarm did not fire");
endmodule : rtca_match

// File: design/rtca_pkg.sv
/*
  types of the alarm unit: the state records of its three modules.
  assumes nothing beyond the defines header.
*/
package rtca_pkg;
  typedef struct packed {
    logic [7:0] min_alm;
    logic [7:0] hour_alm;
    logic [7:0] date_alm;
    logic [7:0] ext_cfg;
    logic [7:0] irq_ctl;
    logic [7:0] rdata;
  } rtca_regs_t;

  typedef struct packed {
    logic evt;
  } rtca_match_st_t;

  typedef struct packed {
    logic af;
    logic drive;
  } rtca_irq_st_t;
endpackage : rtca_pkg

// File: verification/rtca_alarm_interrupt_test.sv
/*
  self-checking bench of the alarm unit with a host model and a driven time keeper.
  assumes the design files are compiled first.
*/
`timescale 1ns/1ps
module rtca_alarm_interrupt_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr, reg_rd, int_n_o, int_n_oe_n, int_line;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic min_tick = 1'b0;
  logic [7:0] min_cnt = 8'h45, hour_cnt = 8'h12, wday_cnt = 8'h08, date_cnt = 8'h23;
  logic [7:0] mask = 8'h2A;
  logic [23:0] ra = 24'h89ADEF;
  int fail_count = 0, check_count = 0, cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  rtca_alarm_top rtca_alarm_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .min_tick(min_tick),
    .min_cnt(min_cnt), .hour_cnt(hour_cnt), .wday_cnt(wday_cnt), .date_cnt(date_cnt),
    .int_n_i(int_line), .int_n_o(int_n_o), .int_n_oe_n(int_n_oe_n));
  rtca_host_model rtca_host_model_inst (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_n_o(int_n_o),
    .int_n_oe_n(int_n_oe_n), .int_line(int_line));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rtca_host_model_inst.rd(a, d);
    chk(d, exp);
  endtask : rchk
  task automatic ochk(input logic e);
    chk({7'h00, int_n_oe_n}, {7'h00, e});
  endtask : ochk
  // release lands at most one cycle after the clearing write
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  // ----------------------------------------
  // time keeper and alarm helpers
  // ----------------------------------------
  task automatic tick(input logic [7:0] m, input logic [7:0] h, input logic [7:0] w, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    {min_cnt, hour_cnt, wday_cnt, date_cnt} = {m, h, w, d};
    min_tick = 1'b1;
    @(posedge clk_sys);
    #1;
    min_tick = 1'b0;
    settle();
  endtask : tick
  task automatic alarm(input logic [7:0] m, input logic [7:0] h, input logic [7:0] w, input logic [7:0] d,
                       input logic af, input logic oe);
    tick(m, h, w, d);
    ochk(oe);
    rchk(4'hE, {4'h0, af, 3'h0});
    rtca_host_model_inst.wr(4'hE, 8'h00);
    settle();
    ochk(1'b1);
  endtask : alarm
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      end_sim();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rchk(ra[20-4*i +: 4], 8'h00);
    end
    for (int i = 8; i < 11; i++) begin
      rtca_host_model_inst.wr(4'(i), 8'hFF);
      rchk(4'(i), 8'hFF);
    end
    rtca_host_model_inst.wr(4'h1, 8'hFF);
    rchk(4'h1, 8'h45);
    rtca_host_model_inst.wr(4'h5, 8'hFF);
    rchk(4'h5, 8'h00);
    rtca_host_model_inst.wr(4'hE, 8'hFF);
    rchk(4'hE, 8'h00);
    rtca_host_model_inst.wr(4'hF, 8'hFF);
    rchk(4'hF, 8'hFD);
    // enable off while programming
    rtca_host_model_inst.wr(4'hF, 8'h00);
    rtca_host_model_inst.wr(4'hD, 8'h00);
    rtca_host_model_inst.wr(4'h8, 8'h30);
    rtca_host_model_inst.wr(4'h9, 8'h07);
    rtca_host_model_inst.wr(4'hA, 8'h80);
    rtca_host_model_inst.wr(4'hF, 8'h08);
    alarm(8'h29, 8'h07, 8'h01, 8'h01, 1'b0, 1'b1);
    alarm(8'h30, 8'h08, 8'h01, 8'h01, 1'b0, 1'b1);
    tick(8'h30, 8'h07, 8'h02, 8'h05);
    ochk(1'b0);
    chk({7'h00, int_line}, 8'h00);
    tick(8'h31, 8'h07, 8'h02, 8'h05);
    repeat (40) @(posedge clk_sys);
    #1;
    ochk(1'b0);
    rtca_host_model_inst.wr(4'hE, 8'h08);
    rchk(4'hE, 8'h08);
    rtca_host_model_inst.wr(4'hE, 8'h00);
    settle();
    ochk(1'b1);
    rchk(4'hE, 8'h00);
    tick(8'h30, 8'h07, 8'h02, 8'h05);
    ochk(1'b0);
    rtca_host_model_inst.wr(4'hF, 8'h00);
    settle();
    ochk(1'b1);
    rchk(4'hE, 8'h08);
    rtca_host_model_inst.wr(4'hE, 8'h00);
    alarm(8'h30, 8'h07, 8'h04, 8'h05, 1'b1, 1'b1);
    rtca_host_model_inst.other(1'b0);
    @(posedge clk_sys);
    #1;
    chk({7'h00, int_line}, 8'h00);
    ochk(1'b1);
    rtca_host_model_inst.other(1'b1);
    // weekday mask: mon, wed, fri
    rtca_host_model_inst.wr(4'hF, 8'h08);
    rtca_host_model_inst.wr(4'h8, 8'h80);
    rtca_host_model_inst.wr(4'h9, 8'h80);
    rtca_host_model_inst.wr(4'hA, mask);
    for (int i = 0; i < 7; i++) begin
      alarm(8'h00, 8'h00, 8'h01 << i, 8'h01, mask[i], !mask[i]);
    end
    rtca_host_model_inst.wr(4'hD, 8'h40);
    rtca_host_model_inst.wr(4'hA, 8'h15);
    alarm(8'h00, 8'h00, 8'h01, 8'h14, 1'b0, 1'b1);
    alarm(8'h00, 8'h00, 8'h02, 8'h15, 1'b1, 1'b0);
    rtca_host_model_inst.wr(4'hA, 8'h80);
    alarm(8'h12, 8'h05, 8'h40, 8'h31, 1'b1, 1'b0);
    alarm(8'h13, 8'h05, 8'h40, 8'h31, 1'b1, 1'b0);
    rtca_host_model_inst.wr(4'hF, 8'h09);
    alarm(8'h14, 8'h05, 8'h40, 8'h31, 1'b0, 1'b1);
    rtca_host_model_inst.wr(4'hF, 8'h08);
    repeat (10) @(posedge clk_sys);
    rchk(4'hE, 8'h00);
    end_sim();
  end
endmodule : rtca_alarm_interrupt_test

// File: verification/rtca_host_model.sv
/*
  host-side model: drives the register port and senses the shared interrupt line.
  assumes the alarm unit samples strobes on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
module rtca_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // interrupt line
  input wire logic int_n_o,
  input wire logic int_n_oe_n,
  output logic int_line
);
  logic other_n;
  // ----------------------------------------
  // wired line
  // ----------------------------------------
  // pull-up: high only when every party lets go
  assign int_line = (int_n_oe_n ? 1'b1 : int_n_o) & other_n;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    other_n = 1'b1;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // address and data scrambled after use, so stale values never help
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
  // another source pulling the shared line
  task automatic other(input logic n);
    @(posedge clk_sys);
    #1;
    other_n = n;
  endtask : other
endmodule : rtca_host_model
